// ===== hdl/digital_port_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module digital_port_handshake #(
  parameter int NPORT = dph_pkg::NUM_PORTS,
  parameter logic [3:0] PORT_LINES_FULL = 4'hf, // 1: port has 8 lines
  parameter logic [3:0] FIXED_IN = 4'h0, // port permanently input
  parameter logic [3:0] FIXED_OUT = 4'h0, // port permanently output
  parameter logic [3:0] LINE_DIR_OK = 4'hf, // per-line direction allowed
  parameter int NARROW_LINES = 4 // line count of a narrow port
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire dph_pkg::dph_wr_t hostWr, // host port data write
  input wire logic dirWrEn, // host direction write strobe
  input wire logic [1:0] dirPort, // port index for direction write
  input wire logic [7:0] dirData, // 1 per line = output
  input wire logic [7:0] portGroup, // 2 bits per port, group code
  input wire logic [1:0] grpHandshake, // handshaked mode per group
  input wire logic [1:0] grpStatClr, // clear group latched and accepted flags
  input wire logic [1:0] readPort, // port index for host read
  output logic [7:0] readData, // read value of readPort
  input wire logic [31:0] linesIn, // pin input levels, 8 per port
  output logic [31:0] linesOut, // pin drive values
  output logic [31:0] linesOe, // pin output enables, high drives
  input wire logic [1:0] reqIn, // group request lines
  output logic [1:0] ackOut, // group acknowledge lines
  output logic [31:0] grpInData, // latched data of group one
  output logic [31:0] grpInData2, // latched data of group two
  output dph_pkg::dph_grp_stat_t [1:0] grpStat // group status
);
  typedef struct packed {
    logic [3:0][7:0] dir;
    logic [3:0][7:0] outv;
    logic [1:0][31:0] latch;
    logic [1:0] reqPrev;
    logic [1:0][3:0] ackCnt;
    dph_pkg::dph_grp_stat_t [1:0] stat;
    logic [7:0] rd;
  } dph_state_t;

  dph_state_t st_reg;
  dph_state_t st_next;

  // mask of valid lines, narrow ports drop upper bits
  function automatic logic [7:0] lineMask(input logic [1:0] p);
    lineMask = PORT_LINES_FULL[p] ? 8'hff :
      8'((16'h0001 << NARROW_LINES) - 16'h0001);
  endfunction

  // member of group g (0 or 1)
  function automatic logic inGroup(input logic [1:0] p, input logic g);
    logic [1:0] code;
    code = portGroup[2*p +: 2];
    inGroup = g ? (code == dph_pkg::GRP_TWO) : (code == dph_pkg::GRP_ONE);
  endfunction

  // effective direction respects fixed ports
  function automatic logic [7:0] effDir(input logic [1:0] p,
                                        input logic [7:0] d);
    if (FIXED_IN[p]) begin
      effDir = 8'h00;
    end else if (FIXED_OUT[p]) begin
      effDir = 8'hff;
    end else if (LINE_DIR_OK[p]) begin
      effDir = d;
    end else begin
      effDir = {8{d[0]}};
    end
  endfunction

  // how a transfer runs, as seen from the pins:
  // - a write to a member port of a live group updates the lines at
  //   the next edge and raises the group acknowledge for one pulse
  // - a rising request on a live group latches every input member at
  //   the next edge, acknowledges, and marks a pending write accepted
  // - port p fills bits 8p+7 down to 8p of its group word, so a pair
  //   or a four-port group reads back as one wide word
  // - requests are edge-taken; a far side that holds its request high
  //   must drop it before the next transfer can be taken
  // - nothing here waits: the design cannot stall the far side, so a
  //   request that comes faster than software reads the word overwrites
  //   the latch, and the latched flag is the only warning
  // - narrow ports never drive or report their missing lines
  // - a group in handshaked mode with no member port, or with members
  //   that do not form a legal width, answers nothing at all
  // - a clear and a request in the same cycle leave the flag set, so a
  //   latch that lands while software clears is never lost
  // - write acknowledge and request acknowledge share one pulse line;
  //   the far side tells them apart by the way it is moving data

  // request edges: reqPrev follows the pin every cycle, so a level held
  // high over several cycles is one request, not a stream of them;
  // reqPrev resets low, the idle level, so reset alone makes no edge
  logic [1:0] reqRise;
  assign reqRise = reqIn & ~st_reg.reqPrev;

  // a group is one port, an aligned pair of ports or all four; any other
  // member set is not a legal width and does not handshake
  function automatic logic shapeOk(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h2, 4'h4, 4'h8: shapeOk = 1'b1;
      4'h3, 4'hc: shapeOk = 1'b1;
      4'hf: shapeOk = 1'b1;
      default: shapeOk = 1'b0;
    endcase
  endfunction

  // member ports of each group, one bit per port
  logic [1:0][3:0] grpMembers;
  always_comb begin
    grpMembers = '0;
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 4; p++) begin
        grpMembers[g][p] = inGroup(2'(p), g[0]);
      end
    end
  end

  // a group handshakes only in handshaked mode with a legal member set;
  // an empty group would otherwise answer requests with no data moved
  logic [1:0] grpShapeOk;
  logic [1:0] grpLive;
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      grpShapeOk[g] = shapeOk(grpMembers[g]);
    end
  end
  assign grpLive = grpHandshake & grpShapeOk;

  // host writes that a live group must announce with a pulse
  logic [1:0] wrAnnounce;
  always_comb begin
    wrAnnounce = 2'h0;
    for (int g = 0; g < 2; g++) begin
      if (hostWr.wrEn && grpLive[g]) begin
        wrAnnounce[g] = grpMembers[g][hostWr.port];
      end
    end
  end

  // request edges taken by a live group
  logic [1:0] reqTaken;
  assign reqTaken = reqRise & grpLive;

  // groups whose acknowledge starts this cycle, from either cause
  logic [1:0] ackStart;
  assign ackStart = wrAnnounce | reqTaken;

  // input members of each group; an output member has nothing to latch,
  // and a port turned half way round is left out until it is all input
  logic [1:0][3:0] latchSel;
  always_comb begin
    latchSel = '0;
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 4; p++) begin
        latchSel[g][p] = grpMembers[g][p] && st_reg.dir[p] == 8'h00;
      end
    end
  end

  // byte seen on a read: driven state on output lines, pin level on
  // input lines; a mixed port is resolved line by line
  function automatic logic [7:0] portView(input logic [1:0] p);
    for (int b = 0; b < 8; b++) begin
      portView[b] = st_reg.dir[p][b] ? st_reg.outv[p][b] :
        linesIn[8*p + b];
    end
    portView = portView & lineMask(p);
  endfunction

  // next-state logic
  always_comb begin
    logic [1:0] pi;
    logic handshaked;
    pi = 2'h0;
    handshaked = 1'b0;
    st_next = st_reg;
    st_next.reqPrev = reqIn;

    // pulses run down first so that a new event can restart them
    for (int g = 0; g < 2; g++) begin
      if (st_reg.ackCnt[g] != 4'h0) begin
        st_next.ackCnt[g] = st_reg.ackCnt[g] - 4'h1;
      end
      // a clear yields to a request edge in the same cycle
      if (grpStatClr[g]) begin
        st_next.stat[g].latched = 1'b0;
        st_next.stat[g].accepted = 1'b0;
      end
    end

    // direction writes; fixed ports keep their setting
    if (dirWrEn) begin
      st_next.dir[dirPort] = effDir(dirPort, dirData) & lineMask(dirPort);
    end

    // host data writes; plain mode updates the lines at once
    if (hostWr.wrEn) begin
      pi = hostWr.port;
      st_next.outv[pi] = hostWr.data & lineMask(pi);
    end

    // a handshaked write goes out at once and stays pending until the far side takes it
    for (int g = 0; g < 2; g++) begin
      handshaked = wrAnnounce[g];
      if (handshaked) begin
        st_next.stat[g].pending = 1'b1;
        st_next.stat[g].accepted = 1'b0;
      end
    end

    // request: all all-input member ports latch on the same edge
    for (int g = 0; g < 2; g++) begin
      if (reqTaken[g]) begin
        for (int p = 0; p < 4; p++) begin
          if (latchSel[g][p]) begin
            st_next.latch[g][8*p +: 8] =
              linesIn[8*p +: 8] & lineMask(2'(p));
            st_next.stat[g].latched = 1'b1;
          end
        end
        if (st_reg.stat[g].pending) begin
          st_next.stat[g].accepted = 1'b1;
          st_next.stat[g].pending = 1'b0;
        end
      end
    end

    // one place restarts the pulse, so back-to-back events stretch it
    for (int g = 0; g < 2; g++) begin
      if (ackStart[g]) begin
        st_next.ackCnt[g] = 4'(dph_pkg::ACK_CYCLES);
      end
    end

    // read-back is registered, one cycle behind readPort
    st_next.rd = portView(readPort);
  end

  // state register; reset leaves every line undriven except on fixed output ports
  // fixed output ports come up driving their reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      for (int p = 0; p < 4; p++) begin
        st_reg.dir[p] <= FIXED_OUT[p] ? 8'hff : dph_pkg::DIR_RESET;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // pin drive follows the output register whatever the direction, so
  // turning a port round shows the last written value at once
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      linesOut[8*p +: 8] = st_reg.outv[p];
    end
  end

  // enables come from direction; lines a narrow port lacks stay off
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      linesOe[8*p +: 8] = st_reg.dir[p] & lineMask(2'(p));
    end
  end

  // acknowledge stands while its counter runs
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      ackOut[g] = st_reg.ackCnt[g] != 4'h0;
    end
  end

  // group words and status flags come straight from flip-flops;
  // the flags are levels that stand until cleared or replaced
  assign readData = st_reg.rd;
  assign grpInData = st_reg.latch[0];
  assign grpInData2 = st_reg.latch[1];
  assign grpStat = st_reg.stat;
endmodule
`default_nettype wire

// ===== hdl/dph_pkg.sv
package dph_pkg;
  // port geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_WIDTH = 8;
  localparam int NUM_GROUPS = 2;
  localparam int GROUP_WIDTH = NUM_PORTS * PORT_WIDTH;
  // group membership codes per port
  localparam logic [1:0] GRP_NONE = 2'h0;
  localparam logic [1:0] GRP_ONE = 2'h1;
  localparam logic [1:0] GRP_TWO = 2'h2;
  // reset values
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  // acknowledge pulse length in cycles
  localparam int ACK_CYCLES = 1;
  localparam int ACK_CNT_W = 4;

  // host-side access of one port
  typedef struct packed {
    logic wrEn;
    logic [1:0] port;
    logic [7:0] data;
  } dph_wr_t;

  typedef struct packed {
    logic latched;
    logic accepted;
    logic pending;
  } dph_grp_stat_t;
endpackage

// ===== verif/dph_partner.sv
`timescale 1ns/1ps
`default_nettype none
// external equipment: drives released lines, raises requests on command
module dph_partner (
  input wire logic clk, // system clock
  input wire logic [31:0] linesOut, // device drive
  input wire logic [31:0] linesOe, // device enables
  input wire logic [31:0] drive, // level the equipment puts out
  input wire logic [1:0] pulse, // request command from bench
  output logic [31:0] linesIn, // resolved pin level
  output logic [1:0] reqIn // request lines
);
  // driven bits read back the device value, the rest the equipment's
  assign linesIn = (linesOe & linesOut) | (~linesOe & drive);
  always_ff @(posedge clk) reqIn <= pulse;
endmodule
`default_nettype wire

// ===== verif/dph_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dph_port_asserts (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire dph_pkg::dph_wr_t hostWr, // host write
  input wire logic [7:0] portGroup, // group codes
  input wire logic [1:0] grpHandshake, // handshaked mode
  input wire logic [31:0] linesIn, // pin levels
  input wire logic [31:0] linesOut, // pin drive
  input wire logic [31:0] linesOe, // pin enables
  input wire logic [1:0] reqIn, // requests
  input wire logic [1:0] ackOut, // acknowledges
  input wire logic [31:0] grpInData, // group one word
  input wire dph_pkg::dph_grp_stat_t [1:0] grpStat // status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff rst;
  // a request edge on group one in handshaked mode with port zero a member; member set shape is not checked
  sequence reqTake;
    $rose(reqIn[0]) && grpHandshake[0] &&
      portGroup[1:0] == dph_pkg::GRP_ONE;
  endsequence
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> linesOe == 32'h0 && ackOut == 2'h0) else $error("not idle");
  plain_no_ack_a: assert property (!$past(grpHandshake[0]) |->
    !ackOut[0]) else $error("ack in plain mode");
  ack_cause_a: assert property (ackOut[0] |-> $past(grpHandshake[0]))
    else $error("ack without handshake");
  req_ack_a: assert property (reqTake |=> ackOut[0])
    else $error("no ack after request");
  latch_data_a: assert property (reqTake ##0 linesOe[7:0] == 8'h0 |=>
    grpInData[7:0] == $past(linesIn[7:0])) else $error("bad latch");
  latch_flag_a: assert property (reqTake |=> grpStat[0].latched)
    else $error("latched flag low");
  out_write_a: assert property (hostWr.wrEn && hostWr.port == 2'h0 &&
    linesOe[7:0] == 8'hff |=> linesOut[7:0] == $past(hostWr.data))
    else $error("line drive wrong");
  no_group_a: assert property ($past(portGroup) == 8'h0 |->
    ackOut == 2'h0) else $error("ack when ungrouped");
endmodule
bind digital_port_handshake dph_port_asserts u_dph_port_asserts (.*);
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 0, rst = 1, dirWrEn = 0;
  logic [1:0] dirPort = 0, grpHandshake = 0, grpStatClr = 0, readPort = 0;
  logic [1:0] pulse = 0, reqIn, ackOut;
  logic [7:0] dirData = 0, portGroup = 0, readData;
  logic [31:0] drive = 0, linesIn, linesOut, linesOe, grpInData, grpInData2;
  dph_pkg::dph_wr_t hostWr = '0;
  dph_pkg::dph_grp_stat_t [1:0] grpStat;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  digital_port_handshake u_digital_port_handshake (.*);
  dph_partner u_dph_partner (.*);
  always #25 clk = ~clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task wr(input logic [1:0] p, input logic [7:0] d);
    hostWr = '{1'b1, p, d};
    @(posedge clk) #5 hostWr.wrEn = 0;
  endtask
  task dirw(input logic [1:0] p, input logic [7:0] d);
    {dirWrEn, dirPort, dirData} = {1'b1, p, d};
    @(posedge clk) #5 dirWrEn = 0;
    @(posedge clk) #5;
  endtask
  task rd(input logic [1:0] p, input logic [7:0] e);
    readPort = p;
    @(posedge clk) #5 `CHK("readData", e, readData)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #5 rst = 0;
    `CHK("oe", 32'h0, linesOe)
    `CHK("stat", 6'h0, grpStat)
    dirw(0, 8'hff);
    wr(0, 8'ha5);
    `CHK("out0", 8'ha5, linesOut[7:0])
    rd(0, 8'ha5);
    drive = 32'h3c00;
    rd(1, 8'h3c);
    dirw(2, 8'h0f);
    wr(2, 8'hf0);
    `CHK("oe2", 8'h0f, linesOe[23:16])
    `CHK("out2", 8'hf0, linesOut[23:16])
    {portGroup, grpHandshake} = {8'h01, 2'h1};
    wr(0, 8'h5a);
    `CHK("ack", 2'h1, ackOut)
    dirw(0, 8'h00);
    dirw(2, 8'h00);
    // all four ports in group one form one 32-bit word
    {portGroup, drive, pulse} = {8'h55, 32'h12345678, 2'h1};
    repeat (2) @(posedge clk);
    #5 `CHK("word", 32'h12345678, grpInData)
    `CHK("group_one_acknowledge_out", 2'h1, ackOut)
    `CHK("latched", 1'b1, grpStat[0].latched)
    `CHK("accepted", 1'b1, grpStat[0].accepted)
    grpStatClr = 2'h1;
    @(posedge clk) #5 grpStatClr = 2'h0;
    `CHK("clr", 2'h0, {grpStat[0].latched, grpStat[0].accepted})
    {portGroup, grpHandshake, pulse} = {8'h00, 2'h3, 2'h0};
    @(posedge clk) #5 pulse = 2'h3;
    repeat (2) @(posedge clk);
    #5 `CHK("noack", 2'h0, ackOut)
    report_and_stop;
  end
endmodule
`default_nettype wire
